// >>> hdl/vector_lane_unit.v
// four-lane single-precision vector unit with axi4-lite control registers
// assumes the core holds an instruction until taken and answers MEM_REQ with MEM_ACK
// Function
// - scalar float operations run only while status word bit 16 is one.
// - vector operations run only while status word bit 17 is one.
// - core 0 vector unit also needs option byte word three bit 16.
// - core 2 vector unit also needs option byte word three bit 18.
// - a vector is four independent 32-bit float lanes, 128 bits.
// - quad load reads 128 bits at the address into four lanes.
// - masked load writes one word into lanes whose mask bit is set.
// - quad store writes all four lanes as 128 bits to memory.
// - lane add sums corresponding lanes in single precision.
// - lane subtract takes lane differences in single precision.
// - lane divide returns four single-precision quotients.
// - fused multiply-add multiplies two lanes and adds the third.
// - lane extract returns the indexed lane as a scalar.
// - word accesses need word alignment, quad accesses 16-byte alignment.
`timescale 1ns/1ps
`default_nettype none
`include "vlu_defines.vh"

module vector_lane_unit #(
	parameter [1:0] CORE_INDEX = 2'h0
) (
	// clock and reset
	input wire CLK,
	input wire NRST,
	// core enables
	input wire [31:0] CORE_STATUS_WORD,
	input wire [31:0] OPTION_BYTE_WORD_THREE,
	// instruction
	input wire INSN_VALID,
	output wire INSN_READY,
	input wire [2:0] INSN_OP,
	input wire INSN_SCALAR,
	input wire [2:0] INSN_DST,
	input wire [2:0] INSN_SRC_A,
	input wire [2:0] INSN_SRC_B,
	input wire [2:0] INSN_SRC_C,
	input wire [3:0] INSN_IMM,
	input wire [31:0] INSN_ADDR,
	// completion
	output wire DONE,
	output wire EXC_UNUSABLE,
	output wire EXC_MISALIGN,
	output wire [31:0] RESULT,
	// memory
	output wire MEM_REQ,
	output wire MEM_WRITE,
	output wire MEM_QUAD,
	output wire [31:0] MEM_ADDR,
	output wire [127:0] MEM_WDATA,
	input wire MEM_ACK,
	input wire [127:0] MEM_RDATA,
	// axi4-lite write
	input wire [7:0] AWADDR,
	input wire AWVALID,
	output wire AWREADY,
	input wire [31:0] WDATA,
	input wire [3:0] WSTRB,
	input wire WVALID,
	output wire WREADY,
	output wire [1:0] BRESP,
	output wire BVALID,
	input wire BREADY,
	// axi4-lite read
	input wire [7:0] ARADDR,
	input wire ARVALID,
	output wire ARREADY,
	output wire [31:0] RDATA,
	output wire [1:0] RRESP,
	output wire RVALID,
	input wire RREADY,
	// interrupt
	output wire IRQ
);

localparam [2:0] S_IDLE = 3'h0;
localparam [2:0] S_RA = 3'h1;
localparam [2:0] S_RB = 3'h2;
localparam [2:0] S_RC = 3'h3;
localparam [2:0] S_RD = 3'h4;
localparam [2:0] S_MEM = 3'h5;
localparam [2:0] S_EXEC = 3'h6;
localparam [2:0] S_DONE = 3'h7;

// ----------------------------------------
// float helpers
// ----------------------------------------
function [31:0] fp_pack;
	input s;
	input integer e;
	input [23:0] m;
	input g;
	input st;
	reg [24:0] r;
	integer ex;
	begin
		r = {1'b0, m} + {24'h0, g & (st | m[0])};
		ex = e;
		if (r[24]) begin
			r = r >> 1;
			ex = ex + 1;
		end
		if (ex >= 255) fp_pack = {s, 8'hFF, 23'h0};
		else if (ex <= 0) fp_pack = {s, 31'h0};
		else fp_pack = {s, ex[7:0], r[22:0]};
	end
endfunction

function [51:0] shr_sticky;
	input [51:0] v;
	input integer d;
	reg [51:0] t;
	begin
		if (d > 51) begin
			shr_sticky = {51'h0, |v};
		end else begin
			t = v >> d;
			shr_sticky = t | {51'h0, (t << d) != v};
		end
	end
endfunction

function is_nan;
	input [31:0] a;
	is_nan = (a[30:23] == 8'hFF) & (|a[22:0]);
endfunction

function is_inf;
	input [31:0] a;
	is_inf = (a[30:23] == 8'hFF) & ~(|a[22:0]);
endfunction

function [23:0] mant;
	input [31:0] a;
	mant = (a[30:23] == 8'h00) ? 24'h0 : {1'b1, a[22:0]};
endfunction

// a*b+c with one rounding at the end, subnormals flushed
function [31:0] fp_fma;
	input [31:0] a;
	input [31:0] b;
	input [31:0] c;
	reg [47:0] p;
	reg [51:0] x, y, s, t;
	reg sp, sr;
	integer ep, ec, e, msb, k;
	begin
		sp = a[31] ^ b[31];
		p = mant(a) * mant(b);
		ep = a[30:23] + b[30:23] - 127;
		ec = c[30:23];
		x = {1'b0, p, 3'h0};
		y = {2'h0, mant(c), 26'h0};
		if (is_nan(a) | is_nan(b) | is_nan(c) | (is_inf(a) & mant(b) == 24'h0) |
			(is_inf(b) & mant(a) == 24'h0) | ((is_inf(a) | is_inf(b)) & is_inf(c) &
			(sp != c[31]))) begin
			fp_fma = `FP_QNAN;
		end else if (is_inf(a) | is_inf(b)) begin
			fp_fma = {sp, 8'hFF, 23'h0};
		end else if (is_inf(c)) begin
			fp_fma = c;
		end else if (p == 48'h0) begin
			fp_fma = (mant(c) == 24'h0) ? {sp & c[31], 31'h0} : c;
		end else begin
			if (mant(c) == 24'h0) ec = ep - 60;
			if (ep >= ec) begin
				e = ep;
				y = shr_sticky(y, ep - ec);
			end else begin
				e = ec;
				x = shr_sticky(x, ec - ep);
			end
			if (sp == c[31]) begin
				s = x + y;
				sr = sp;
			end else if (x >= y) begin
				s = x - y;
				sr = sp;
			end else begin
				s = y - x;
				sr = c[31];
			end
			msb = 0;
			for (k = 0; k < 52; k = k + 1) begin
				if (s[k]) msb = k;
			end
			t = s << (51 - msb);
			if (s == 52'h0) fp_fma = 32'h0;
			else fp_fma = fp_pack(sr, e + msb - 49, t[51:28], t[27], |t[26:0]);
		end
	end
endfunction

function [31:0] fp_div;
	input [31:0] a;
	input [31:0] b;
	reg [49:0] q, r;
	reg s;
	integer e;
	begin
		s = a[31] ^ b[31];
		q = {mant(a), 26'h0} / {26'h0, mant(b)};
		r = {mant(a), 26'h0} % {26'h0, mant(b)};
		e = a[30:23] - b[30:23] + 127;
		if (is_nan(a) | is_nan(b) | (is_inf(a) & is_inf(b)) |
			(mant(a) == 24'h0 & mant(b) == 24'h0)) begin
			fp_div = `FP_QNAN;
		end else if (is_inf(a) | mant(b) == 24'h0) begin
			fp_div = {s, 8'hFF, 23'h0};
		end else if (mant(a) == 24'h0 | is_inf(b)) begin
			fp_div = {s, 31'h0};
		end else if (q[26]) begin
			fp_div = fp_pack(s, e, q[26:3], q[2], (|q[1:0]) | (r != 50'h0));
		end else begin
			fp_div = fp_pack(s, e - 1, q[25:2], q[1], q[0] | (r != 50'h0));
		end
	end
endfunction

function reg_mapped;
	input [7:0] a;
	reg_mapped = (a == `REG_INT_STATUS) | (a == `REG_INT_CLEAR) | (a == `REG_INT_ENABLE) |
		(a == `REG_CONTROL) | (a == `REG_UNIT_STATE) | (a == `REG_LAST_RESULT);
endfunction

// ----------------------------------------
// state and storage
// ----------------------------------------
reg [2:0] state_q, op_q, dst_q, srca_q, srcb_q, srcc_q;
reg [3:0] imm_q;
reg scalar_q, done_q, exc_un_q, exc_mis_q;
reg [31:0] addr_q, result_q;
reg [127:0] opa_q, opb_q, opc_q, res_q, lane_res, merge_res;
reg [2:0] rf_raddr;
reg [`EV_WIDTH-1:0] int_status_q, int_enable_q;
reg hold_q, aw_full_q, w_full_q, wstrb0_q, bvalid_q, rvalid_q;
reg [7:0] awaddr_q;
reg [31:0] wdata_q, rdata_q, rd_word;
reg [1:0] bresp_q, rresp_q;
wire [127:0] rf_rdata;
integer i;

// ----------------------------------------
// issue checks
// ----------------------------------------
wire opt_ok = (CORE_INDEX == 2'h0) ? OPTION_BYTE_WORD_THREE[`CORE0_VECTOR_UNIT_ENABLE_BIT] :
	(CORE_INDEX == 2'h2) ? OPTION_BYTE_WORD_THREE[`CORE2_VECTOR_UNIT_ENABLE_BIT] : 1'b0;
wire vec_ok = CORE_STATUS_WORD[`VECTOR_FP_ENABLE_BIT] & opt_ok;
wire scalar_arith = INSN_SCALAR & (INSN_OP >= `OP_LANE_ADD) & (INSN_OP <= `OP_LANE_FMA);
wire unusable = scalar_arith ? ~CORE_STATUS_WORD[`SCALAR_FP_ENABLE_BIT] : ~vec_ok;
wire misalign = ((INSN_OP == `OP_QUAD_LOAD) | (INSN_OP == `OP_QUAD_STORE)) ? |INSN_ADDR[3:0] :
	(INSN_OP == `OP_MASKED_LOAD) ? |INSN_ADDR[1:0] : 1'b0;
wire accept = INSN_VALID & INSN_READY;
wire is_mem = (op_q == `OP_QUAD_LOAD) | (op_q == `OP_MASKED_LOAD) | (op_q == `OP_QUAD_STORE);
wire is_arith = (op_q >= `OP_LANE_ADD) & (op_q <= `OP_LANE_FMA);
wire rf_we = (state_q == S_DONE) & ~exc_un_q & ~exc_mis_q & ((op_q == `OP_QUAD_LOAD) |
	(op_q == `OP_MASKED_LOAD) | (is_arith & ~scalar_q));

assign INSN_READY = (state_q == S_IDLE) & ~hold_q;
assign DONE = done_q;
assign EXC_UNUSABLE = exc_un_q;
assign EXC_MISALIGN = exc_mis_q;
assign RESULT = result_q;
assign MEM_REQ = (state_q == S_MEM);
assign MEM_WRITE = (op_q == `OP_QUAD_STORE);
assign MEM_QUAD = (op_q != `OP_MASKED_LOAD);
assign MEM_ADDR = addr_q;
assign MEM_WDATA = opa_q;

// ----------------------------------------
// operand reads and lane datapath
// ----------------------------------------
always @* begin
	case (state_q)
		S_RA: rf_raddr = (op_q == `OP_MASKED_LOAD) ? dst_q : srca_q;
		S_RB: rf_raddr = srcb_q;
		S_RC: rf_raddr = srcc_q;
		default: rf_raddr = srca_q;
	endcase
end

always @* begin
	lane_res = opa_q;
	merge_res = opa_q;
	for (i = 0; i < 4; i = i + 1) begin
		if (op_q == `OP_LANE_DIV) begin
			lane_res[32*i +: 32] = fp_div(opa_q[32*i +: 32], opb_q[32*i +: 32]);
		end else if (op_q == `OP_LANE_FMA) begin
			lane_res[32*i +: 32] = fp_fma(opa_q[32*i +: 32], opb_q[32*i +: 32],
				opc_q[32*i +: 32]);
		end else if (op_q == `OP_LANE_SUB) begin
			lane_res[32*i +: 32] = fp_fma(opa_q[32*i +: 32], `FP_ONE,
				{~opb_q[32*i+31], opb_q[32*i +: 31]});
		end else begin
			lane_res[32*i +: 32] = fp_fma(opa_q[32*i +: 32], `FP_ONE, opb_q[32*i +: 32]);
		end
		if (imm_q[i]) merge_res[32*i +: 32] = MEM_RDATA[31:0];
	end
end

vector_regfile regs (
	.clk(CLK),
	.nrst(NRST),
	.we(rf_we),
	.waddr(dst_q),
	.wdata(res_q),
	.raddr(rf_raddr),
	.rdata_q(rf_rdata)
);

// ----------------------------------------
// sequencer
// ----------------------------------------
always @(posedge CLK or negedge NRST) begin
	if (!NRST) begin
		state_q <= S_IDLE;
		op_q <= 3'h0;
		scalar_q <= 1'b0;
		dst_q <= 3'h0;
		srca_q <= 3'h0;
		srcb_q <= 3'h0;
		srcc_q <= 3'h0;
		imm_q <= 4'h0;
		addr_q <= 32'h0;
		opa_q <= 128'h0;
		opb_q <= 128'h0;
		opc_q <= 128'h0;
		res_q <= 128'h0;
		result_q <= 32'h0;
		done_q <= 1'b0;
		exc_un_q <= 1'b0;
		exc_mis_q <= 1'b0;
	end else begin
		done_q <= 1'b0;
		case (state_q)
			S_IDLE: begin
				if (accept) begin
					op_q <= INSN_OP;
					scalar_q <= scalar_arith;
					dst_q <= INSN_DST;
					srca_q <= INSN_SRC_A;
					srcb_q <= INSN_SRC_B;
					srcc_q <= INSN_SRC_C;
					imm_q <= INSN_IMM;
					addr_q <= INSN_ADDR;
					exc_un_q <= unusable;
					exc_mis_q <= ~unusable & misalign;
					if (unusable | misalign) begin
						done_q <= 1'b1;
						state_q <= S_DONE;
					end else begin
						state_q <= S_RA;
					end
				end
			end
			S_RA: state_q <= S_RB;
			S_RB: begin
				opa_q <= rf_rdata;
				state_q <= S_RC;
			end
			S_RC: begin
				opb_q <= rf_rdata;
				state_q <= S_RD;
			end
			S_RD: begin
				opc_q <= rf_rdata;
				state_q <= is_mem ? S_MEM : S_EXEC;
			end
			S_MEM: begin
				if (MEM_ACK) begin
					res_q <= (op_q == `OP_QUAD_LOAD) ? MEM_RDATA : merge_res;
					done_q <= 1'b1;
					state_q <= S_DONE;
				end
			end
			S_EXEC: begin
				res_q <= lane_res;
				result_q <= (op_q == `OP_LANE_EXTRACT) ? opa_q[32*imm_q[1:0] +: 32] :
					lane_res[31:0];
				done_q <= 1'b1;
				state_q <= S_DONE;
			end
			default: begin
				exc_un_q <= 1'b0;
				exc_mis_q <= 1'b0;
				state_q <= S_IDLE;
			end
		endcase
	end
end

// ----------------------------------------
// register bus
// ----------------------------------------
wire do_write = aw_full_q & w_full_q & ~bvalid_q;
wire [`EV_WIDTH-1:0] events = {exc_mis_q & done_q, exc_un_q & done_q, done_q};
wire [`EV_WIDTH-1:0] clr = (do_write & wstrb0_q & (awaddr_q == `REG_INT_CLEAR)) ?
	wdata_q[`EV_WIDTH-1:0] : {`EV_WIDTH{1'b0}};

assign AWREADY = ~aw_full_q & ~bvalid_q;
assign WREADY = ~w_full_q & ~bvalid_q;
assign BVALID = bvalid_q;
assign BRESP = bresp_q;
assign ARREADY = ~rvalid_q;
assign RVALID = rvalid_q;
assign RDATA = rdata_q;
assign RRESP = rresp_q;
assign IRQ = |(int_status_q & int_enable_q);

always @* begin
	case (ARADDR)
		`REG_INT_STATUS: rd_word = {29'h0, int_status_q};
		`REG_INT_ENABLE: rd_word = {29'h0, int_enable_q};
		`REG_CONTROL: rd_word = {31'h0, hold_q};
		`REG_UNIT_STATE: rd_word = {26'h0, CORE_STATUS_WORD[`SCALAR_FP_ENABLE_BIT], vec_ok,
			(state_q != S_IDLE), state_q};
		`REG_LAST_RESULT: rd_word = result_q;
		default: rd_word = 32'h0;
	endcase
end

always @(posedge CLK or negedge NRST) begin
	if (!NRST) begin
		aw_full_q <= 1'b0;
		w_full_q <= 1'b0;
		awaddr_q <= 8'h00;
		wdata_q <= 32'h0;
		wstrb0_q <= 1'b0;
		bvalid_q <= 1'b0;
		bresp_q <= `RESP_OKAY;
		rvalid_q <= 1'b0;
		rdata_q <= 32'h0;
		rresp_q <= `RESP_OKAY;
		int_status_q <= {`EV_WIDTH{1'b0}};
		int_enable_q <= `INT_ENABLE_RESET;
		hold_q <= `CONTROL_HOLD_RESET;
	end else begin
		int_status_q <= (int_status_q & ~clr) | events;
		if (AWVALID & AWREADY) begin
			aw_full_q <= 1'b1;
			awaddr_q <= AWADDR;
		end
		if (WVALID & WREADY) begin
			w_full_q <= 1'b1;
			wdata_q <= WDATA;
			wstrb0_q <= WSTRB[0];
		end
		if (do_write) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			bvalid_q <= 1'b1;
			bresp_q <= reg_mapped(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
			if (wstrb0_q & (awaddr_q == `REG_INT_ENABLE)) int_enable_q <= wdata_q[`EV_WIDTH-1:0];
			if (wstrb0_q & (awaddr_q == `REG_CONTROL)) hold_q <= wdata_q[`CONTROL_HOLD_BIT];
		end else if (bvalid_q & BREADY) begin
			bvalid_q <= 1'b0;
		end
		if (ARVALID & ARREADY) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= reg_mapped(ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rvalid_q & RREADY) begin
			rvalid_q <= 1'b0;
		end
	end
end

endmodule
`default_nettype wire

// >>> hdl/vlu_defines.vh
// constants for the four-lane float vector unit
// included by every design file; definitions only
`ifndef VLU_DEFINES_VH
`define VLU_DEFINES_VH

// ----------------------------------------
// enable bits of the core status word and option byte word three
// ----------------------------------------
`define SCALAR_FP_ENABLE_BIT 16
`define VECTOR_FP_ENABLE_BIT 17
`define CORE0_VECTOR_UNIT_ENABLE_BIT 16
`define CORE2_VECTOR_UNIT_ENABLE_BIT 18

// ----------------------------------------
// instruction codes
// ----------------------------------------
`define OP_QUAD_LOAD 3'h0
`define OP_MASKED_LOAD 3'h1
`define OP_QUAD_STORE 3'h2
`define OP_LANE_ADD 3'h3
`define OP_LANE_SUB 3'h4
`define OP_LANE_DIV 3'h5
`define OP_LANE_FMA 3'h6
`define OP_LANE_EXTRACT 3'h7

// ----------------------------------------
// register offsets, fields and reset values
// ----------------------------------------
`define REG_INT_STATUS 8'h00
`define REG_INT_CLEAR 8'h04
`define REG_INT_ENABLE 8'h08
`define REG_CONTROL 8'h0C
`define REG_UNIT_STATE 8'h10
`define REG_LAST_RESULT 8'h14
`define EV_DONE 0
`define EV_UNUSABLE 1
`define EV_MISALIGN 2
`define EV_WIDTH 3
`define CONTROL_HOLD_BIT 0
`define INT_ENABLE_RESET 3'h0
`define CONTROL_HOLD_RESET 1'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------
// float constants and storage size
// ----------------------------------------
`define FP_QNAN 32'h7FC00000
`define FP_ONE 32'h3F800000
`define VREG_COUNT 8

`endif

// >>> hdl/vector_regfile.v
// eight 128-bit vector registers, one write port, one registered read port
// assumes one clock; read data appear one edge after the address
`timescale 1ns/1ps
`default_nettype none
`include "vlu_defines.vh"

module vector_regfile (
	// clock and reset
	input wire clk,
	input wire nrst,
	// write port
	input wire we,
	input wire [2:0] waddr,
	input wire [127:0] wdata,
	// read port
	input wire [2:0] raddr,
	output reg [127:0] rdata_q
);

reg [127:0] mem_q [0:`VREG_COUNT-1];

// ----------------------------------------
// storage
// ----------------------------------------
always @(posedge clk) begin
	if (we) begin
		mem_q[waddr] <= wdata;
	end
end

always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		rdata_q <= 128'h0;
	end else begin
		rdata_q <= mem_q[raddr];
	end
end

endmodule
`default_nettype wire

// >>> testbench/vlu_checker_asserts.sv
// assertions on the vector lane unit ports
// bound into every vector_lane_unit instance
`timescale 1ns/1ps
`default_nettype none
module vlu_checker #(
	parameter [1:0] CORE_INDEX = 2'h0
) (
	// clock, reset, enables
	input wire logic CLK,
	input wire logic NRST,
	input wire logic [31:0] CORE_STATUS_WORD,
	input wire logic [31:0] OPTION_BYTE_WORD_THREE,
	// instruction
	input wire logic INSN_VALID,
	input wire logic INSN_READY,
	input wire logic [2:0] INSN_OP,
	input wire logic INSN_SCALAR,
	input wire logic [31:0] INSN_ADDR,
	input wire logic DONE,
	input wire logic EXC_UNUSABLE,
	input wire logic EXC_MISALIGN,
	// memory
	input wire logic MEM_REQ,
	input wire logic MEM_WRITE,
	input wire logic MEM_QUAD,
	input wire logic [31:0] MEM_ADDR,
	input wire logic MEM_ACK
);
	logic take, opt_en, scal, unus, mis, memop;
	assign take = INSN_VALID && INSN_READY;
	assign opt_en = CORE_INDEX == 2'h0 ? OPTION_BYTE_WORD_THREE[16] :
		CORE_INDEX == 2'h2 && OPTION_BYTE_WORD_THREE[18];
	assign scal = INSN_SCALAR && INSN_OP >= 3'h3 && INSN_OP <= 3'h6;
	assign unus = scal ? !CORE_STATUS_WORD[16] : !(CORE_STATUS_WORD[17] && opt_en);
	assign memop = INSN_OP <= 3'h2;
	assign mis = INSN_OP == 3'h1 ? INSN_ADDR[1:0] != 2'h0 : memop && INSN_ADDR[3:0] != 4'h0;
	// ----
	// properties
	// ----
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);
	sequence s_refused;
		DONE && EXC_UNUSABLE && !EXC_MISALIGN && !MEM_REQ;
	endsequence
	sequence s_arith;
		!DONE [*5] ##1 (DONE && !EXC_UNUSABLE && !EXC_MISALIGN);
	endsequence
	sequence s_request;
		!MEM_REQ [*4] ##1 (MEM_REQ && MEM_ADDR == $past(INSN_ADDR, 5) &&
			MEM_WRITE == ($past(INSN_OP, 5) == 3'h2) && MEM_QUAD == ($past(INSN_OP, 5) != 3'h1));
	endsequence
	a_unusable_refused: assert property (take && unus |=> s_refused)
		else $error("disabled unit not refused");
	a_scalar_enable: assert property (take && scal && CORE_STATUS_WORD[16] |=> !EXC_UNUSABLE)
		else $error("enabled scalar op refused");
	a_option_gate: assert property (take && !scal && !opt_en |=> EXC_UNUSABLE)
		else $error("option enable ignored");
	a_misalign_caught: assert property (take && !unus && mis |=>
		DONE && EXC_MISALIGN && !EXC_UNUSABLE && !MEM_REQ) else $error("misalign missed");
	a_lane_timing: assert property (take && !unus && INSN_OP >= 3'h3 |=> s_arith)
		else $error("lane op not done in six cycles");
	a_mem_request: assert property (take && !unus && !mis && memop |=> s_request)
		else $error("memory request wrong");
	a_request_held: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR))
		else $error("request dropped early");
	a_ack_completes: assert property (MEM_REQ && MEM_ACK |=> DONE && !MEM_REQ)
		else $error("no completion after ack");
endmodule
bind vector_lane_unit vlu_checker #(.CORE_INDEX(CORE_INDEX)) i_chk (
	.CLK(CLK), .NRST(NRST), .CORE_STATUS_WORD(CORE_STATUS_WORD),
	.OPTION_BYTE_WORD_THREE(OPTION_BYTE_WORD_THREE), .INSN_VALID(INSN_VALID),
	.INSN_READY(INSN_READY), .INSN_OP(INSN_OP), .INSN_SCALAR(INSN_SCALAR),
	.INSN_ADDR(INSN_ADDR), .DONE(DONE), .EXC_UNUSABLE(EXC_UNUSABLE),
	.EXC_MISALIGN(EXC_MISALIGN), .MEM_REQ(MEM_REQ), .MEM_WRITE(MEM_WRITE),
	.MEM_QUAD(MEM_QUAD), .MEM_ADDR(MEM_ADDR), .MEM_ACK(MEM_ACK)
);
`default_nettype wire

// >>> testbench/core_memory_model.sv
// memory beside the vector unit, answering after a set stall
// assumes each request holds until acknowledged
`timescale 1ns/1ps
`default_nettype none
module core_memory_model (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// request
	input wire logic mem_req,
	input wire logic mem_write,
	input wire logic mem_quad,
	input wire logic [31:0] mem_addr,
	input wire logic [127:0] mem_wdata,
	input wire logic [3:0] stall,
	// answer
	output logic mem_ack,
	output logic [127:0] mem_rdata
);
	logic [127:0] mem [0:15];
	logic [127:0] line;
	logic [3:0] wait_q;
	assign line = mem[mem_addr[7:4]];
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mem_ack <= 1'b0;
			wait_q <= 4'h0;
			mem_rdata <= 128'h0;
		end else if (mem_req && !mem_ack && wait_q == stall) begin
			mem_ack <= 1'b1;
			wait_q <= 4'h0;
			if (mem_write)
				mem[mem_addr[7:4]] <= mem_wdata;
			else if (mem_quad)
				mem_rdata <= line;
			else
				mem_rdata <= {~line[127:32], line[{mem_addr[3:2], 5'h0} +: 32]};
		end else begin
			mem_ack <= 1'b0;
			wait_q <= mem_req && !mem_ack ? wait_q + 4'h1 : 4'h0;
			// released data keep changing
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule
`default_nettype wire

// >>> testbench/test_fp_simd_vector_lane_unit.sv
// self-checking bench for the four-lane float vector unit
// assumes the memory model and the bound checker compile alongside
`timescale 1ns/1ps
`default_nettype none
module test_fp_simd_vector_lane_unit;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [31:0] csw = 32'h00030000;
	logic [31:0] opt = 32'h00010000;
	logic iv = 1'b0;
	logic scalar = 1'b0;
	logic [2:0] op = 3'h0, dst = 3'h0, sa = 3'h0, sb = 3'h0, sc = 3'h0;
	logic [3:0] imm = 4'h0;
	logic [3:0] stall = 4'h0;
	logic [31:0] addr = 32'h0, wdata = 32'h0, rd;
	logic [7:0] awaddr = 8'h0, araddr = 8'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [1:0] rr;
	wire ready, done, exu, exm, mreq, mwr, mquad, mack, awready, wready, bvalid;
	wire arready, rvalid, irq;
	wire [31:0] result, maddr, rdata;
	wire [127:0] mwdata, mrdata;
	wire [1:0] rresp, bresp;
	integer errors = 0;
	integer n_checks = 0;
	logic [31:0] lv [0:3] = '{32'h3F800000, 32'h40000000, 32'h40400000, 32'h40800000};
	logic [31:0] tbl [0:15] = '{32'h40400000, 32'h40800000, 32'h40A00000, 32'h40C00000,
		32'hBF800000, 32'h00000000, 32'h3F800000, 32'h40000000,
		32'h3F000000, 32'h3F800000, 32'h3FC00000, 32'h40000000,
		32'h40400000, 32'h40C00000, 32'h41100000, 32'h41400000};
	always #2 clk = ~clk;
	vector_lane_unit #(.CORE_INDEX(2'h0)) i_dut (
		.CLK(clk), .NRST(nrst), .CORE_STATUS_WORD(csw), .OPTION_BYTE_WORD_THREE(opt),
		.INSN_VALID(iv), .INSN_READY(ready), .INSN_OP(op), .INSN_SCALAR(scalar),
		.INSN_DST(dst), .INSN_SRC_A(sa), .INSN_SRC_B(sb), .INSN_SRC_C(sc),
		.INSN_IMM(imm), .INSN_ADDR(addr), .DONE(done), .EXC_UNUSABLE(exu),
		.EXC_MISALIGN(exm), .RESULT(result), .MEM_REQ(mreq), .MEM_WRITE(mwr),
		.MEM_QUAD(mquad), .MEM_ADDR(maddr), .MEM_WDATA(mwdata), .MEM_ACK(mack),
		.MEM_RDATA(mrdata), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
		.WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
		.BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
		.ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
		.RREADY(rready), .IRQ(irq));
	core_memory_model i_mem (.clk(clk), .nrst(nrst), .mem_req(mreq), .mem_write(mwr),
		.mem_quad(mquad), .mem_addr(maddr), .mem_wdata(mwdata), .stall(stall),
		.mem_ack(mack), .mem_rdata(mrdata));
	// ----
	// shared tasks
	// ----
	task chk(input [127:0] got, input [127:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task wrap_up;
		begin
			$display("checks %0d mismatches %0d", n_checks, errors);
			if (errors == 0 && n_checks > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	task issue(input [2:0] o, d, a, b, c, input [3:0] im, input [31:0] ad, input [1:0] exc);
		integer n;
		begin
			n = 0;
			@(posedge clk);
			op <= o;
			dst <= d;
			sa <= a;
			sb <= b;
			sc <= c;
			imm <= im;
			addr <= ad;
			iv <= 1'b1;
			@(negedge clk);
			while (ready !== 1'b1 && n < 50) begin
				@(negedge clk);
				n = n + 1;
			end
			@(posedge clk);
			iv <= 1'b0;
			@(negedge clk);
			while (done !== 1'b1 && n < 100) begin
				@(negedge clk);
				n = n + 1;
			end
			chk({done, exu, exm}, {1'b1, exc});
		end
	endtask
	task ext(input [2:0] v, input [1:0] l, input [31:0] e);
		begin
			issue(3'h7, v, v, 3'h0, 3'h0, {2'h0, l}, 32'h0, 2'h0);
			chk(result, e);
		end
	endtask
	task axw(input [7:0] a, input [31:0] d);
		integer n;
		logic at, wt, bt;
		begin
			n = 0;
			bt = 1'b0;
			@(posedge clk);
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			while (!bt && n < 50) begin
				@(negedge clk);
				n = n + 1;
				at = awvalid && awready;
				wt = wvalid && wready;
				bt = bvalid;
				rr = bresp;
				@(posedge clk);
				if (at) awvalid <= 1'b0;
				if (wt) wvalid <= 1'b0;
				if (bt) bready <= 1'b0;
			end
		end
	endtask
	task axr(input [7:0] a);
		integer n;
		logic at, rt;
		begin
			n = 0;
			rt = 1'b0;
			@(posedge clk);
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			while (!rt && n < 50) begin
				@(negedge clk);
				n = n + 1;
				at = arvalid && arready;
				rt = rvalid;
				rd = rdata;
				rr = rresp;
				@(posedge clk);
				if (at) arvalid <= 1'b0;
				if (rt) rready <= 1'b0;
			end
		end
	endtask
	// ----
	// scenarios
	// ----
	task t_load;
		integer i;
		begin
			axr(8'h08);
			chk({rr, rd, irq}, 35'h0);
			issue(3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 4'h0, 32'h00, 2'h0);
			@(posedge clk);
			stall <= 4'h3;
			issue(3'h0, 3'h1, 3'h1, 3'h0, 3'h0, 4'h0, 32'h10, 2'h0);
			for (i = 0; i < 4; i = i + 1) begin
				ext(3'h0, i[1:0], lv[i]);
				ext(3'h1, i[1:0], 32'h40000000);
			end
			$display("load test done");
		end
	endtask
	task t_arith;
		integer k, i;
		begin
			for (k = 0; k < 4; k = k + 1) begin
				issue(3'h3 + k[2:0], 3'h3, 3'h0, 3'h1, 3'h0, 4'h0, 32'h0, 2'h0);
				chk(result, tbl[4 * k]);
				for (i = 0; i < 4; i = i + 1)
					ext(3'h3, i[1:0], tbl[4 * k + i]);
			end
			issue(3'h2, 3'h3, 3'h3, 3'h0, 3'h0, 4'h0, 32'h20, 2'h0);
			chk(i_mem.mem[2], {tbl[15], tbl[14], tbl[13], tbl[12]});
			$display("arith test done");
		end
	endtask
	task t_enables;
		begin
			@(posedge clk);
			csw <= 32'h00010000;
			issue(3'h3, 3'h0, 3'h0, 3'h1, 3'h0, 4'h0, 32'h0, 2'h2);
			@(posedge clk);
			scalar <= 1'b1;
			issue(3'h3, 3'h0, 3'h0, 3'h1, 3'h0, 4'h0, 32'h0, 2'h0);
			chk(result, 32'h40400000);
			issue(3'h7, 3'h0, 3'h0, 3'h0, 3'h0, 4'h0, 32'h0, 2'h2);
			@(posedge clk);
			csw <= 32'h00020000;
			issue(3'h3, 3'h0, 3'h0, 3'h1, 3'h0, 4'h0, 32'h0, 2'h2);
			@(posedge clk);
			scalar <= 1'b0;
			csw <= 32'h00030000;
			opt <= 32'h00040000;
			issue(3'h3, 3'h0, 3'h0, 3'h1, 3'h0, 4'h0, 32'h0, 2'h2);
			@(posedge clk);
			opt <= 32'h00050000;
			$display("enable test done");
		end
	endtask
	task t_mask_align;
		integer i;
		begin
			issue(3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 4'h5, 32'h34, 2'h0);
			for (i = 0; i < 4; i = i + 1)
				ext(3'h0, i[1:0], i[0] ? lv[i] : 32'h41100000);
			issue(3'h0, 3'h5, 3'h5, 3'h0, 3'h0, 4'h0, 32'h08, 2'h1);
			issue(3'h1, 3'h5, 3'h5, 3'h0, 3'h0, 4'h1, 32'h36, 2'h1);
			issue(3'h2, 3'h3, 3'h3, 3'h0, 3'h0, 4'h0, 32'h24, 2'h1);
			issue(3'h1, 3'h5, 3'h5, 3'h0, 3'h0, 4'h1, 32'h38, 2'h0);
			$display("mask and alignment test done");
		end
	endtask
	task t_irq;
		begin
			axr(8'h00);
			chk({rd, irq}, 33'hE);
			axw(8'h08, 32'h2);
			@(negedge clk);
			chk(irq, 1'b1);
			axw(8'h04, 32'h2);
			axr(8'h00);
			chk({rd, irq}, 33'hA);
			axw(8'h0C, 32'h1);
			@(negedge clk);
			chk(ready, 1'b0);
			axw(8'h0C, 32'h0);
			chk(rr, 2'h0);
			axw(8'h20, 32'h1);
			chk(rr, 2'h2);
			axr(8'h14);
			chk(rd, 32'h40800000);
			axr(8'h20);
			chk(rr, 2'h2);
			$display("interrupt test done");
		end
	endtask
	initial begin
		i_mem.mem[0] = {lv[3], lv[2], lv[1], lv[0]};
		i_mem.mem[1] = {4{32'h40000000}};
		i_mem.mem[3] = {64'h0, 32'h41100000, 32'h0};
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		t_load;
		t_arith;
		t_enables;
		t_mask_align;
		t_irq;
		wrap_up;
	end
	initial begin
		#40000;
		errors = errors + 1;
		wrap_up;
	end
endmodule
`default_nettype wire
